// ---- rtl/async_serial_transceiver.sv ----
// Asynchronous serial transceiver: registers, baud generator, transmitter, receiver
// Functional notes
// - Transmit and receive enables both set out of reset.
// - Clearing module enable lets the current character finish, then stops.
// - Transmit start bit, data LSB first, optional parity, stop bits.
// - Receive after valid start; overrun, parity, framing, break stored with data.
// - Divisor is 16-bit integer plus 6-bit fraction in two registers.
// - Divisor equals system clock over sixteen times baud rate.
// - Oversample tick at 16x baud; 16 ticks per transmitted bit.
// - Divisors and line control staged in 30 bits, loaded on line-control write.
// - Character length five to eight bits both directions.
// - Even, odd, stick or no parity, generated and checked.
// - One or two transmitted stop bits.
// - Drive break on transmit output, detect break on receive.
// - Start low not held to mid-bit is ignored as false start.
// - FIFO trigger levels 1/8, 1/4, 1/2, 3/4, 7/8.
// - FIFO depth programmable, including one-entry holding register mode.
// - Baud generator reaches 3.125 Mbps where system clock allows.
// - Independent transmit and receive FIFOs.
// - Start bit resampled on eighth tick, accepted only if still low.
// - Data and parity sampled every sixteenth tick after start.
// - Stop bit must be high, else framing error.
// - Each FIFO holds sixteen entries in FIFO mode.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
module async_serial_transceiver
  import serial_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [BUS_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [BUS_W-1:0] rdata,
  output logic txd,
  input wire logic rxd
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CTL_W-1:0] ctl;
    logic [INT_W-1:0] ibrd;
    logic [FRAC_W-1:0] fbrd;
    logic [IFLS_W-1:0] ifls;
    logic [STAGE_W-1:0] stage;
    logic [INT_W-1:0] baud_cnt;
    logic [FRAC_W-1:0] frac_acc;
    logic tick;
    line_state_e tx_state;
    logic [TICK_W-1:0] tx_cnt;
    logic [BIT_W-1:0] tx_bit;
    logic [DATA_W-1:0] tx_shift;
    logic tx_par;
    logic txd;
    line_state_e rx_state;
    logic [TICK_W-1:0] rx_cnt;
    logic [BIT_W-1:0] rx_bit;
    logic [DATA_W-1:0] rx_shift;
    logic rx_par;
    logic oe_pend;
    logic [RSR_W-1:0] rsr;
    logic [BUS_W-1:0] rdata;
  } core_s;

  core_s s_r;
  core_s s_nxt;

  logic [LCR_W-1:0] lcr;
  logic [INT_W-1:0] div_int;
  logic [FRAC_W-1:0] div_frac;
  logic [BIT_W-1:0] bit_last;
  logic en;
  logic rx_in;
  logic wr_data;
  logic rd_data;
  logic tx_pop;
  logic tx_full;
  logic tx_empty;
  logic [DATA_W-1:0] tx_head;
  logic [LVL_W-1:0] tx_level;
  logic rx_push;
  logic [ENTRY_W-1:0] rx_entry;
  logic rx_full;
  logic rx_empty;
  logic [ENTRY_W-1:0] rx_head;
  logic [LVL_W-1:0] rx_level;
  logic busy;
  logic tx_hit;
  logic rx_hit;

  // Frame format comes only from the staged copy, never straight from the shadows
  assign {div_int, div_frac, lcr} = s_r.stage;
  assign bit_last = BIT_LAST_BASE + {1'b0, lcr[LCR_WLEN +: WLEN_W]};
  assign en = s_r.ctl[CTL_EN];
  assign rx_in = s_r.ctl[CTL_LBE] ? s_r.txd : rxd;
  assign wr_data = wr && (addr == OFS_DATA);
  assign rd_data = rd && (addr == OFS_DATA);
  assign busy = (s_r.tx_state != ST_IDLE) || !tx_empty;
  assign tx_hit = tx_level <= trigger_level(s_r.ifls[0 +: SEL_W]);
  assign rx_hit = rx_level >= trigger_level(s_r.ifls[SEL_W +: SEL_W]);
  assign rdata = s_r.rdata;
  assign txd = s_r.txd;

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  // Separate storage per direction; a write to a full transmit FIFO is dropped
  serial_fifo #(.WIDTH(DATA_W)) u_tx_fifo (
    .clock(clock),
    .rst(rst),
    .one_deep(!lcr[LCR_FEN]),
    .push(wr_data),
    .push_data(wdata[DATA_W-1:0]),
    .pop(tx_pop),
    .head(tx_head),
    .full(tx_full),
    .empty(tx_empty),
    .level(tx_level)
  );

  serial_fifo #(.WIDTH(ENTRY_W)) u_rx_fifo (
    .clock(clock),
    .rst(rst),
    .one_deep(!lcr[LCR_FEN]),
    .push(rx_push),
    .push_data(rx_entry),
    .pop(rd_data),
    .head(rx_head),
    .full(rx_full),
    .empty(rx_empty),
    .level(rx_level)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [INT_W:0] reload;
    logic [FRAC_W:0] acc_sum;
    logic [DATA_W-1:0] rx_data;
    logic rx_zero;
    reload = '0;
    acc_sum = '0;
    rx_data = '0;
    rx_zero = 1'b0;
    s_nxt = s_r;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_entry = '0;

    // Register writes
    if (wr) begin
      case (addr)
        OFS_IBRD: s_nxt.ibrd = wdata[INT_W-1:0];
        OFS_FBRD: s_nxt.fbrd = wdata[FRAC_W-1:0];
        OFS_LCRH: s_nxt.stage = {s_r.ibrd, s_r.fbrd, wdata[LCR_W-1:0]};
        OFS_CTL: s_nxt.ctl = wdata[CTL_W-1:0];
        OFS_IFLS: s_nxt.ifls = wdata[IFLS_W-1:0];
        OFS_RSR: s_nxt.rsr = '0;
        default: ;
      endcase
    end

    // Read data stands only in the cycle after the strobe
    s_nxt.rdata = '0;
    if (rd) begin
      case (addr)
        OFS_DATA: s_nxt.rdata = BUS_W'(rx_empty ? '0 : rx_head);
        OFS_RSR: s_nxt.rdata = BUS_W'(s_r.rsr);
        OFS_FLAG: s_nxt.rdata = BUS_W'({rx_hit, tx_hit, tx_empty, rx_full, tx_full, rx_empty, busy, 3'h0});
        OFS_IBRD: s_nxt.rdata = BUS_W'(s_r.ibrd);
        OFS_FBRD: s_nxt.rdata = BUS_W'(s_r.fbrd);
        OFS_LCRH: s_nxt.rdata = BUS_W'(lcr);
        OFS_CTL: s_nxt.rdata = BUS_W'(s_r.ctl);
        OFS_IFLS: s_nxt.rdata = BUS_W'(s_r.ifls);
        default: s_nxt.rdata = '0;
      endcase
    end
    // Framing, parity and break flags of the word just read become visible in the status register
    if (rd_data && !rx_empty) begin
      s_nxt.rsr[RSR_W-2:0] = rx_head[ERR_FE +: RSR_W-1];
    end

    // Fractional baud generator: period is integer part plus one on fraction carry
    s_nxt.tick = 1'b0;
    if (div_int == '0) begin
      s_nxt.baud_cnt = '0;
    end else if (s_r.baud_cnt == '0) begin
      s_nxt.tick = 1'b1;
      acc_sum = {1'b0, s_r.frac_acc} + {1'b0, div_frac};
      s_nxt.frac_acc = acc_sum[FRAC_W-1:0];
      reload = {1'b0, div_int} + {{INT_W{1'b0}}, acc_sum[FRAC_W]} - (INT_W+1)'(1);
      s_nxt.baud_cnt = reload[INT_W-1:0];
    end else begin
      s_nxt.baud_cnt = s_r.baud_cnt - INT_W'(1);
    end

    // Transmitter
    case (s_r.tx_state)
      ST_IDLE: begin
        // New characters start only while enabled; a running one always completes
        if (en && s_r.ctl[CTL_TXE] && !tx_empty && !lcr[LCR_BRK]) begin
          tx_pop = 1'b1;
          s_nxt.tx_shift = tx_head & word_mask(lcr[LCR_WLEN +: WLEN_W]);
          s_nxt.tx_par = parity_bit(tx_head, lcr);
          s_nxt.tx_state = ST_START;
          s_nxt.tx_cnt = '0;
          s_nxt.tx_bit = '0;
        end
      end
      default: begin
        if (s_r.tick) begin
          s_nxt.tx_cnt = s_r.tx_cnt + TICK_W'(1);
          if (s_r.tx_cnt == TICK_LAST) begin
            case (s_r.tx_state)
              ST_START: s_nxt.tx_state = ST_DATA;
              ST_DATA: begin
                s_nxt.tx_shift = s_r.tx_shift >> 1;
                s_nxt.tx_bit = s_r.tx_bit + BIT_W'(1);
                if (s_r.tx_bit == bit_last) begin
                  s_nxt.tx_state = lcr[LCR_PEN] ? ST_PAR : ST_STOP;
                end
              end
              ST_PAR: s_nxt.tx_state = ST_STOP;
              ST_STOP: s_nxt.tx_state = lcr[LCR_STP2] ? ST_STOP2 : ST_IDLE;
              default: s_nxt.tx_state = ST_IDLE;
            endcase
          end
        end
      end
    endcase
    case (s_nxt.tx_state)
      ST_START: s_nxt.txd = 1'b0;
      ST_DATA: s_nxt.txd = s_nxt.tx_shift[0];
      ST_PAR: s_nxt.txd = s_nxt.tx_par;
      default: s_nxt.txd = 1'b1;
    endcase
    if (lcr[LCR_BRK]) begin
      s_nxt.txd = 1'b0;
    end

    // Receiver
    rx_data = s_r.rx_shift & word_mask(lcr[LCR_WLEN +: WLEN_W]);
    rx_zero = (rx_data == '0) && !(lcr[LCR_PEN] && s_r.rx_par) && !rx_in;
    case (s_r.rx_state)
      ST_IDLE: begin
        s_nxt.rx_cnt = '0;
        if (en && s_r.ctl[CTL_RXE] && !rx_in) begin
          s_nxt.rx_state = ST_START;
        end
      end
      default: begin
        if (s_r.tick) begin
          s_nxt.rx_cnt = s_r.rx_cnt + TICK_W'(1);
          if (s_r.rx_state == ST_START && s_r.rx_cnt == TICK_MID) begin
            s_nxt.rx_cnt = '0;
            s_nxt.rx_bit = '0;
            s_nxt.rx_shift = '0;
            s_nxt.rx_state = rx_in ? ST_IDLE : ST_DATA;
          end else if (s_r.rx_state != ST_START && s_r.rx_cnt == TICK_LAST) begin
            case (s_r.rx_state)
              ST_DATA: begin
                s_nxt.rx_shift[s_r.rx_bit] = rx_in;
                s_nxt.rx_bit = s_r.rx_bit + BIT_W'(1);
                if (s_r.rx_bit == bit_last) begin
                  s_nxt.rx_state = lcr[LCR_PEN] ? ST_PAR : ST_STOP;
                end
              end
              ST_PAR: begin
                s_nxt.rx_par = rx_in;
                s_nxt.rx_state = ST_STOP;
              end
              default: begin
                // Stop sample completes the character
                s_nxt.rx_state = ST_IDLE;
                rx_push = 1'b1;
                rx_entry[DATA_W-1:0] = rx_data;
                rx_entry[ERR_FE] = !rx_in;
                rx_entry[ERR_PE] = lcr[LCR_PEN] && (s_r.rx_par != parity_bit(rx_data, lcr));
                rx_entry[ERR_BE] = rx_zero;
                rx_entry[ERR_OE] = s_r.oe_pend;
              end
            endcase
          end
        end
      end
    endcase

    // Overrun: the new character is lost and the flag rides with the next stored one
    if (rx_push && rx_full) begin
      s_nxt.oe_pend = 1'b1;
      s_nxt.rsr[RSR_W-1] = 1'b1;
    end else if (rx_push) begin
      s_nxt.oe_pend = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
      s_r.ctl <= CTL_RESET;
      s_r.stage <= STAGE_RESET;
      s_r.ifls <= IFLS_RESET;
      s_r.txd <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_enables_after_reset;
    @(posedge clock) $fell(rst) |-> s_r.ctl[CTL_TXE] && s_r.ctl[CTL_RXE];
  endproperty
  a_enables_after_reset: assert property (p_enables_after_reset) else $error("enables not set after reset");

  property p_finish_char;
    @(posedge clock) disable iff (rst) (s_r.tx_state == ST_DATA && !en) |=> s_r.tx_state != ST_IDLE;
  endproperty
  a_finish_char: assert property (p_finish_char) else $error("character cut short by disable");

  property p_start_low;
    @(posedge clock) disable iff (rst) (s_r.tx_state == ST_START) |-> !txd;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  property p_overrun;
    @(posedge clock) disable iff (rst) (rx_push && rx_full) |=> s_r.oe_pend && s_r.rsr[RSR_W-1];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_tick_paced;
    @(posedge clock) disable iff (rst) (s_r.tx_state != ST_IDLE && !s_r.tick) |=> s_r.tx_state == $past(s_r.tx_state);
  endproperty
  a_tick_paced: assert property (p_tick_paced) else $error("transmit moved without tick");

  property p_stage_load;
    @(posedge clock) disable iff (rst) !(wr && addr == OFS_LCRH) |=> $stable(s_r.stage);
  endproperty
  a_stage_load: assert property (p_stage_load) else $error("staged divisor changed without line write");

  property p_idle_high;
    @(posedge clock) disable iff (rst) (s_r.tx_state == ST_IDLE && !lcr[LCR_BRK]) ##1 (s_r.tx_state == ST_IDLE && !lcr[LCR_BRK]) |-> txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle line not high");

  property p_false_start;
    @(posedge clock) disable iff (rst) (s_r.rx_state == ST_START && s_r.tick && s_r.rx_cnt == TICK_MID && rx_in) |=> s_r.rx_state == ST_IDLE;
  endproperty
  a_false_start: assert property (p_false_start) else $error("false start not ignored");

  property p_stop_sample;
    @(posedge clock) disable iff (rst) rx_push |-> (rx_entry[ERR_FE] == !rx_in) && s_r.rx_cnt == TICK_LAST;
  endproperty
  a_stop_sample: assert property (p_stop_sample) else $error("framing check wrong");

  property p_rx_independent;
    @(posedge clock) disable iff (rst) (wr_data && !rd_data && !rx_push) |=> rx_level == $past(rx_level);
  endproperty
  a_rx_independent: assert property (p_rx_independent) else $error("transmit write disturbed receive FIFO");

endmodule

// ---- rtl/serial_fifo.sv ----
// Sixteen-entry FIFO with a one-entry holding-register mode
`timescale 1ns/1ps
module serial_fifo
  import serial_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic one_deep,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic full,
  output logic empty,
  output logic [LVL_W-1:0] level
);

  typedef struct packed {
    logic [FIFO_DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
    logic [LVL_W-1:0] cnt;
  } fifo_s;

  fifo_s s_r;
  fifo_s s_nxt;
  logic do_push;
  logic do_pop;

  // Depth one gives the plain double-buffered holding register
  assign full = one_deep ? (s_r.cnt != '0) : (s_r.cnt == LVL_W'(FIFO_DEPTH));
  assign empty = (s_r.cnt == '0);
  assign head = s_r.mem[s_r.rp];
  assign level = s_r.cnt;
  assign do_push = push && !full;
  assign do_pop = pop && !empty;

  always_comb begin
    s_nxt = s_r;
    if (do_push) begin
      s_nxt.mem[s_r.wp] = push_data;
      s_nxt.wp = s_r.wp + PTR_W'(1);
    end
    if (do_pop) begin
      s_nxt.rp = s_r.rp + PTR_W'(1);
    end
    if (do_push && !do_pop) begin
      s_nxt.cnt = s_r.cnt + LVL_W'(1);
    end else if (do_pop && !do_push) begin
      s_nxt.cnt = s_r.cnt - LVL_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// ---- rtl/serial_pkg.sv ----
// Shared constants, register map and types of the asynchronous serial transceiver
package serial_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets on the plain register port)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int BUS_W = 32;
  localparam logic [ADDR_W-1:0] OFS_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RSR = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FLAG = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IBRD = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_FBRD = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_LCRH = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_CTL = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_IFLS = 8'h34;

  // ----------------------------------------------------------------
  // Port control register
  // ----------------------------------------------------------------
  localparam int CTL_W = 10;
  localparam int CTL_EN = 0;
  localparam int CTL_LBE = 7;
  localparam int CTL_TXE = 8;
  localparam int CTL_RXE = 9;
  localparam logic [CTL_W-1:0] CTL_RESET = 10'h300;

  // ----------------------------------------------------------------
  // Line control register
  // ----------------------------------------------------------------
  localparam int LCR_W = 8;
  localparam int LCR_BRK = 0;
  localparam int LCR_PEN = 1;
  localparam int LCR_EPS = 2;
  localparam int LCR_STP2 = 3;
  localparam int LCR_FEN = 4;
  localparam int LCR_WLEN = 5;
  localparam int LCR_SPS = 7;
  localparam logic [LCR_W-1:0] LCR_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Baud divisor and staged 30-bit word {integer, fraction, line control}
  // ----------------------------------------------------------------
  localparam int INT_W = 16;
  localparam int FRAC_W = 6;
  localparam int STAGE_W = INT_W + FRAC_W + LCR_W;
  localparam logic [STAGE_W-1:0] STAGE_RESET = 30'h0000_0000;
  localparam int CLK_HZ = 10_000_000;
  localparam int MAX_BAUD = 3_125_000;

  // ----------------------------------------------------------------
  // Oversampling and character timing
  // ----------------------------------------------------------------
  localparam int TICK_W = 4;
  localparam logic [TICK_W-1:0] TICK_LAST = 4'hF;
  localparam logic [TICK_W-1:0] TICK_MID = 4'h7;
  localparam int BIT_W = 3;
  localparam logic [BIT_W-1:0] BIT_LAST_BASE = 3'h4;
  localparam int WLEN_W = 2;
  localparam logic [WLEN_W-1:0] WLEN_MAX = 2'h3;

  // ----------------------------------------------------------------
  // FIFOs, receive entry, flags, trigger levels
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ENTRY_W = 12;
  localparam int ERR_FE = 8;
  localparam int ERR_PE = 9;
  localparam int ERR_BE = 10;
  localparam int ERR_OE = 11;
  localparam int RSR_W = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int LVL_W = 5;
  localparam int FLG_BUSY = 3;
  localparam int FLG_RXFE = 4;
  localparam int FLG_TXFF = 5;
  localparam int FLG_RXFF = 6;
  localparam int FLG_TXFE = 7;
  localparam int FLG_TXHIT = 8;
  localparam int FLG_RXHIT = 9;
  localparam int SEL_W = 3;
  localparam int IFLS_W = 6;
  localparam logic [IFLS_W-1:0] IFLS_RESET = 6'h12;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP, ST_STOP2} line_state_e;

  // Fill level matching 1/8, 1/4, 1/2, 3/4, 7/8 of the depth
  function automatic logic [LVL_W-1:0] trigger_level(input logic [SEL_W-1:0] sel);
    case (sel)
      3'h0: trigger_level = 5'h02;
      3'h1: trigger_level = 5'h04;
      3'h3: trigger_level = 5'h0C;
      3'h4: trigger_level = 5'h0E;
      default: trigger_level = 5'h08;
    endcase
  endfunction

  function automatic logic [DATA_W-1:0] word_mask(input logic [WLEN_W-1:0] wlen);
    word_mask = 8'hFF >> (WLEN_MAX - wlen);
  endfunction

  // Even, odd or stick parity of the masked character
  function automatic logic parity_bit(input logic [DATA_W-1:0] d, input logic [LCR_W-1:0] lcr);
    if (lcr[LCR_SPS]) begin
      parity_bit = ~lcr[LCR_EPS];
    end else begin
      parity_bit = (^(d & word_mask(lcr[LCR_WLEN +: WLEN_W]))) ^ ~lcr[LCR_EPS];
    end
  endfunction

endpackage

// ---- sim/async_serial_transceiver_tb_top.sv ----
// Self-checking testbench of the asynchronous serial transceiver
`timescale 1ns/1ps
module async_serial_transceiver_tb_top
  import serial_pkg::*;
;
  typedef struct {logic [7:0] lcr; logic [7:0] data; logic [BUS_W-1:0] rx_exp;} row_s;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [BUS_W-1:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [BUS_W-1:0] rdata;
  logic txd;
  logic rxd;
  int error_cnt = 0;
  int check_count = 0;
  // Formats: 8N1, 7E1, 6O2, 5 stick-one, 8 stick-zero fifo, 7E2 fifo
  row_s rows [6] = '{'{8'h60, 8'hA5, 32'h0A5}, '{8'h46, 8'hD3, 32'h053}, '{8'h2A, 8'h3C, 32'h03C},
                     '{8'h82, 8'hFF, 32'h01F}, '{8'hF6, 8'h81, 32'h081}, '{8'h5E, 8'h00, 32'h000}};

  always #50 clock = ~clock;

  async_serial_transceiver async_serial_transceiver_inst (.clock(clock), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .txd(txd), .rxd(rxd));
  remote_serial remote_serial_inst (.clock(clock), .txd(txd), .rxd(rxd));

  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [BUS_W-1:0] seen, input logic [BUS_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [BUS_W-1:0] d);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Port held disabled while the divisor and format are rewritten
  task automatic cfg(input logic [15:0] ibrd, input logic [7:0] lcr);
    wr_reg(OFS_CTL, 32'h300);
    wr_reg(OFS_IBRD, {16'h0, ibrd});
    wr_reg(OFS_FBRD, 32'h0);
    wr_reg(OFS_LCRH, {24'h0, lcr});
    wr_reg(OFS_CTL, 32'h301);
  endtask

  function automatic void frame(input logic [7:0] lcr, input logic [7:0] d, output logic [11:0] f, output int n);
    int nb;
    logic p;
    nb = 5 + lcr[LCR_WLEN +: WLEN_W];
    f = 12'hFFF;
    f[0] = 1'b0;
    p = 1'b0;
    for (int i = 0; i < nb; i++) begin
      f[1 + i] = d[i];
      p ^= d[i];
    end
    n = 1 + nb;
    if (lcr[LCR_PEN]) begin
      f[n] = lcr[LCR_SPS] ? ~lcr[LCR_EPS] : p ^ ~lcr[LCR_EPS];
      n++;
    end
    n = n + 1 + lcr[LCR_STP2];
  endfunction

  // A nonzero cut disables the port that many cycles into the character
  task automatic tx_check(input string name, input logic [7:0] lcr, input logic [7:0] d, input int per, input int cut);
    logic [11:0] f;
    logic [11:0] got;
    int n;
    frame(lcr, d, f, n);
    fork
      remote_serial_inst.grab(n, per, got);
      begin
        wr_reg(OFS_DATA, {24'h0, d});
        if (cut > 0) begin
          repeat (cut) @(posedge clock);
          wr_reg(OFS_CTL, 32'h300);
        end
      end
    join
    chk(name, {20'h0, got}, {20'h0, f});
    chk("txd idle", {31'h0, txd}, 32'h1);
  endtask

  // Tail drives a short low stop so the line is high again before any resample
  task automatic rx_check(input string name, input logic [11:0] f, input int n, input int tail,
                          input logic [BUS_W-1:0] mask, input logic [BUS_W-1:0] exp);
    logic [BUS_W-1:0] got;
    remote_serial_inst.send(f, n, 16);
    if (tail > 0) begin
      remote_serial_inst.send(12'h000, 1, tail);
    end
    repeat (4) @(posedge clock);
    rd_reg(OFS_DATA, got);
    chk(name, got & mask, exp);
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [BUS_W-1:0] v;
    logic [11:0] f;
    int n;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rd_reg(OFS_CTL, v);
    chk("ctl reset", v, 32'h300);
    rd_reg(OFS_FLAG, v);
    chk("flag reset", v, 32'h190);
    rd_reg(OFS_IFLS, v);
    chk("trigger reset", v, {26'h0, IFLS_RESET});
    wr_reg(8'h08, 32'hFFFF_FFFF);
    rd_reg(8'h08, v);
    chk("unmapped", v, 32'h0);
    for (int i = 0; i < 6; i++) begin
      cfg(16'h0001, rows[i].lcr);
      tx_check("tx frame", rows[i].lcr, rows[i].data, 16, 0);
      frame(rows[i].lcr, rows[i].data, f, n);
      rx_check("rx word", f, n, 0, 32'hFFFF_FFFF, rows[i].rx_exp);
    end
    // Divisor write without a line-control write must not take effect
    wr_reg(OFS_CTL, 32'h300);
    wr_reg(OFS_IBRD, 32'h2);
    wr_reg(OFS_CTL, 32'h301);
    tx_check("staged divisor", 8'h60, 8'h3C, 16, 0);
    cfg(16'h0002, 8'h60);
    tx_check("divisor two", 8'h60, 8'hC3, 32, 0);
    cfg(16'h0001, 8'h60);
    tx_check("disable mid char", 8'h60, 8'h96, 16, 40);
    cfg(16'h0001, 8'h60);
    frame(8'h60, 8'h5A, f, n);
    rx_check("framing", f, 9, 12, 32'hFFFF_FFFF, 32'h15A);
    rx_check("break", 12'h000, 9, 12, 32'hFFFF_FEFF, 32'h400);
    remote_serial_inst.send(12'h000, 1, 4);
    repeat (200) @(posedge clock);
    rd_reg(OFS_FLAG, v);
    chk("false start", (v >> FLG_RXFE) & 32'h1, 32'h1);
    cfg(16'h0001, 8'h66);
    frame(8'h66, 8'h01, f, n);
    rx_check("parity error", f ^ 12'h200, n, 0, 32'hFFFF_FFFF, 32'h201);
    cfg(16'h0001, 8'h61);
    repeat (20) @(posedge clock);
    chk("break drive", {31'h0, txd}, 32'h0);
    cfg(16'h0001, 8'h60);
    repeat (5) @(posedge clock);
    chk("after break", {31'h0, txd}, 32'h1);
    // Loopback feeds the transmitter straight back into the receiver
    wr_reg(OFS_CTL, 32'h381);
    wr_reg(OFS_DATA, 32'h3C);
    repeat (180) @(posedge clock);
    rd_reg(OFS_DATA, v);
    chk("loopback", v, 32'h03C);
    // Half-step fraction stretches each bit to 24 clocks
    wr_reg(OFS_CTL, 32'h300);
    wr_reg(OFS_FBRD, 32'h20);
    wr_reg(OFS_LCRH, 32'h60);
    wr_reg(OFS_CTL, 32'h301);
    tx_check("fraction half", 8'h60, 8'h69, 24, 0);
    // Second character into the one-entry holding register is lost
    cfg(16'h0001, 8'h60);
    wr_reg(OFS_RSR, 32'h0);
    frame(8'h60, 8'h11, f, n);
    remote_serial_inst.send(f, n, 16);
    rx_check("overrun keep", f ^ 12'h066, n, 0, 32'hFFFF_FFFF, 32'h011);
    rd_reg(OFS_RSR, v);
    chk("overrun status", v, 32'h8);
    rx_check("overrun flag", f, n, 0, 32'hFFFF_FFFF, 32'h811);
    // Mid-run reset brings back the enables and the idle line
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd_reg(OFS_CTL, v);
    chk("ctl mid reset", v, 32'h300);
    chk("txd mid reset", {31'h0, txd}, 32'h1);
    final_report;
  end

  initial begin
    repeat (30000) @(posedge clock);
    error_cnt++;
    $display("ERROR watchdog expected finish seen timeout");
    final_report;
  end
endmodule

// ---- sim/remote_serial.sv ----
// Remote serial device model facing the transceiver's transmit and receive lines
`timescale 1ns/1ps
module remote_serial
  import serial_pkg::*;
(
  input wire logic clock,
  input wire logic txd,
  output logic rxd
);
  // Line idles high, as a pulled-up serial line would
  initial rxd = 1'b1;

  // Waits for a start edge, then samples each bit at its middle
  task automatic grab(input int n, input int per, output logic [11:0] f);
    int k;
    f = 12'hFFF;
    k = 0;
    while (txd !== 1'b0 && k < 4000) begin
      @(posedge clock);
      k++;
    end
    repeat (per / 2) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (per) @(posedge clock);
    end
  endtask

  // Drives bits LSB first, one period each, then releases the line high
  task automatic send(input logic [11:0] f, input int n, input int per);
    @(posedge clock);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (per) @(posedge clock);
    end
    rxd <= 1'b1;
  endtask
endmodule
